// ---- rtl/sdc_pkg.sv ----
// Shared constants, command type and helper functions for the SDRAM device model.
package sdc_pkg;

    // ****************************************************************
    // Geometry
    // ****************************************************************
    localparam int ADDR_W  = 12;
    localparam int BANK_W  = 2;
    localparam int BANKS   = 4;
    localparam int COL_W   = 8;
    localparam int DATA_W  = 16;
    localparam int LEN_W   = 9;
    localparam int PIPE_N  = 3;

    // ****************************************************************
    // Mode word layout and reset value
    // ****************************************************************
    localparam int               MODE_BL_LSB = 0;
    localparam int               MODE_BT_BIT = 3;
    localparam int               MODE_CL_LSB = 4;
    localparam int               MODE_WB_BIT = 9;
    localparam int               AUTO_PRE_BIT = 10;
    localparam logic [ADDR_W-1:0] MODE_RESET = 12'h020;
    localparam logic [2:0]       BL_1    = 3'h0;
    localparam logic [2:0]       BL_2    = 3'h1;
    localparam logic [2:0]       BL_4    = 3'h2;
    localparam logic [2:0]       BL_8    = 3'h3;
    localparam logic [2:0]       BL_PAGE = 3'h7;
    localparam logic [2:0]       CL_3    = 3'h3;
    localparam logic [LEN_W-1:0] LEN_ONE = 9'h001;

    typedef enum logic [3:0] {
        CMD_DESEL, CMD_NOP, CMD_ACT, CMD_READ, CMD_WRITE,
        CMD_PRE, CMD_MODE, CMD_REFRESH, CMD_STOP
    } sdc_cmd_t;

    // Decodes the select and the three strobes into one command.
    function automatic sdc_cmd_t sdc_decode(input logic cs_n, input logic ras_n,
                                            input logic cas_n, input logic we_n);
        sdc_cmd_t c;
        c = CMD_NOP;
        if (cs_n) begin
            c = CMD_DESEL;
        end else begin
            case ({ras_n, cas_n, we_n})
                3'h3: c = CMD_ACT;
                3'h5: c = CMD_READ;
                3'h4: c = CMD_WRITE;
                3'h2: c = CMD_PRE;
                3'h0: c = CMD_MODE;
                3'h1: c = CMD_REFRESH;
                3'h6: c = CMD_STOP;
                default: c = CMD_NOP;
            endcase
        end
        return c;
    endfunction

    // Number of locations in a burst for a length code; unknown codes act as one.
    function automatic logic [LEN_W-1:0] sdc_burst_len(input logic [2:0] code);
        logic [LEN_W-1:0] n;
        n = 9'h001;
        case (code)
            BL_2:    n = 9'h002;
            BL_4:    n = 9'h004;
            BL_8:    n = 9'h008;
            BL_PAGE: n = 9'h100;
            default: n = 9'h001;
        endcase
        return n;
    endfunction

    // Column of step cnt within a burst, wrapping inside the burst-length block.
    function automatic logic [COL_W-1:0] sdc_burst_col(input logic [COL_W-1:0] start,
                                                      input logic [COL_W-1:0] cnt,
                                                      input logic [LEN_W-1:0] len,
                                                      input logic             ileave);
        logic [COL_W-1:0] m;
        logic [COL_W-1:0] low;
        m   = len[COL_W-1:0] - 8'h01;
        low = (ileave && !len[COL_W]) ? ((start ^ cnt) & m) : ((start + cnt) & m);
        return (start & ~m) | low;
    endfunction

endpackage

// ---- rtl/sdc_sdram_device.sv ----
// Command decoder, bank state, burst engine, storage array and read pipeline of the SDRAM.
`timescale 1ns/1ps
module sdc_sdram_device
    import sdc_pkg::*;
#(
    parameter int ROW_BITS = 12
) (
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    input  wire logic              clk_gate,
    input  wire logic              dev_select_n,
    input  wire logic              row_strobe_n,
    input  wire logic              col_strobe_n,
    input  wire logic              write_strobe_n,
    input  wire logic [BANK_W-1:0] bank_select,
    input  wire logic [ADDR_W-1:0] row_col_address,
    input  wire logic              low_byte_mask,
    input  wire logic              high_byte_mask,
    input  wire logic [DATA_W-1:0] data_lines_in,
    output logic      [DATA_W-1:0] data_lines_out,
    output logic      [1:0]        data_lines_oe
);

    // ****************************************************************
    // Command decode
    // ****************************************************************
    sdc_cmd_t cmd;
    assign cmd = sdc_decode(dev_select_n, row_strobe_n, col_strobe_n, write_strobe_n);

    // ****************************************************************
    // Bank, mode and burst state
    // ****************************************************************
    logic [ADDR_W-1:0] mode_reg,        mode_next;
    logic [BANKS-1:0]  row_open_reg,    row_open_next;
    logic [ADDR_W-1:0] open_row_reg  [BANKS];
    logic [ADDR_W-1:0] open_row_next [BANKS];
    logic              burst_active_reg, burst_active_next;
    logic              burst_write_reg,  burst_write_next;
    logic              burst_ap_reg,     burst_ap_next;
    logic [BANK_W-1:0] burst_bank_reg,   burst_bank_next;
    logic [COL_W-1:0]  burst_start_reg,  burst_start_next;
    logic [COL_W-1:0]  burst_cnt_reg,    burst_cnt_next;
    logic [LEN_W-1:0]  burst_len_reg,    burst_len_next;
    logic              acc_en;
    logic              acc_write;
    logic [BANK_W-1:0] acc_bank;
    logic [COL_W-1:0]  acc_col;
    logic [LEN_W-1:0]  new_len;
    logic              burst_last;

    // Mode fields used by the burst engine and the output selector.
    logic [2:0] mode_cl;
    logic       single_write;
    assign mode_cl      = mode_reg[MODE_CL_LSB +: 3];
    assign single_write = mode_reg[MODE_WB_BIT];

    // Next state of banks, mode and burst; a new command overrides the running burst's step.
    always_comb begin
        mode_next         = mode_reg;
        row_open_next     = row_open_reg;
        open_row_next     = open_row_reg;
        burst_active_next = burst_active_reg;
        burst_write_next  = burst_write_reg;
        burst_ap_next     = burst_ap_reg;
        burst_bank_next   = burst_bank_reg;
        burst_start_next  = burst_start_reg;
        burst_cnt_next    = burst_cnt_reg;
        burst_len_next    = burst_len_reg;
        acc_en            = 1'b0;
        acc_write         = burst_write_reg;
        acc_bank          = burst_bank_reg;
        acc_col           = sdc_burst_col(burst_start_reg, burst_cnt_reg, burst_len_reg,
                                          mode_reg[MODE_BT_BIT]);
        burst_last        = ({1'b0, burst_cnt_reg} + LEN_ONE) >= burst_len_reg;
        new_len           = sdc_burst_len(mode_reg[MODE_BL_LSB +: 3]);
        if (cmd == CMD_WRITE && single_write) begin
            new_len = LEN_ONE;
        end
        // A low clk_gate freezes every register, as if the edge never came.
        if (clk_gate) begin
            if (burst_active_reg) begin
                acc_en         = 1'b1;
                burst_cnt_next = burst_cnt_reg + 8'h01;
                if (burst_last) begin
                    burst_active_next = 1'b0;
                    if (burst_ap_reg) begin
                        row_open_next[burst_bank_reg] = 1'b0;
                    end
                end
            end
            case (cmd)
                CMD_ACT: begin
                    row_open_next[bank_select] = 1'b1;
                    open_row_next[bank_select] = row_col_address;
                end
                CMD_READ, CMD_WRITE: begin
                    // Accesses to a closed bank are dropped rather than hitting a stale row.
                    if (row_open_reg[bank_select]) begin
                        acc_en            = 1'b1;
                        acc_write         = (cmd == CMD_WRITE);
                        acc_bank          = bank_select;
                        acc_col           = row_col_address[COL_W-1:0];
                        burst_write_next  = (cmd == CMD_WRITE);
                        burst_bank_next   = bank_select;
                        burst_start_next  = row_col_address[COL_W-1:0];
                        burst_ap_next     = row_col_address[AUTO_PRE_BIT];
                        burst_len_next    = new_len;
                        burst_cnt_next    = 8'h01;
                        burst_active_next = (new_len != LEN_ONE);
                        if (new_len == LEN_ONE && row_col_address[AUTO_PRE_BIT]) begin
                            row_open_next[bank_select] = 1'b0;
                        end
                    end
                end
                CMD_PRE: begin
                    if (row_col_address[AUTO_PRE_BIT]) begin
                        row_open_next     = '0;
                        burst_active_next = 1'b0;
                        acc_en            = 1'b0;
                    end else begin
                        row_open_next[bank_select] = 1'b0;
                        // Other banks keep bursting so precharge hides behind them.
                        if (bank_select == burst_bank_reg) begin
                            burst_active_next = 1'b0;
                            acc_en            = 1'b0;
                        end
                    end
                end
                CMD_STOP: begin
                    burst_active_next = 1'b0;
                    acc_en            = 1'b0;
                end
                CMD_MODE: begin
                    // Loading mid-burst would retime the burst in flight, so it is refused then.
                    if (!burst_active_reg) begin
                        mode_next = row_col_address;
                    end
                end
                default: ;
            endcase
        end
    end

    // Registers of the bank, mode and burst group.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_reg         <= MODE_RESET;
            row_open_reg     <= '0;
            open_row_reg     <= '{default: '0};
            burst_active_reg <= 1'b0;
            burst_write_reg  <= 1'b0;
            burst_ap_reg     <= 1'b0;
            burst_bank_reg   <= '0;
            burst_start_reg  <= '0;
            burst_cnt_reg    <= '0;
            burst_len_reg    <= LEN_ONE;
        end else begin
            mode_reg         <= mode_next;
            row_open_reg     <= row_open_next;
            open_row_reg     <= open_row_next;
            burst_active_reg <= burst_active_next;
            burst_write_reg  <= burst_write_next;
            burst_ap_reg     <= burst_ap_next;
            burst_bank_reg   <= burst_bank_next;
            burst_start_reg  <= burst_start_next;
            burst_cnt_reg    <= burst_cnt_next;
            burst_len_reg    <= burst_len_next;
        end
    end

    // ****************************************************************
    // Storage array and read pipeline
    // ****************************************************************
    localparam int MEM_AW = BANK_W + ROW_BITS + COL_W;
    logic [DATA_W-1:0] mem [2**MEM_AW];
    logic [MEM_AW-1:0] acc_idx;
    logic [ROW_BITS-1:0] acc_row;
    logic              pipe_valid_reg [PIPE_N];
    logic              pipe_valid_next [PIPE_N];
    logic [1:0]        pipe_mask_reg  [PIPE_N];
    logic [1:0]        pipe_mask_next [PIPE_N];
    logic [DATA_W-1:0] pipe_data_reg  [PIPE_N];
    logic [DATA_W-1:0] rd_word;
    logic [1:0]        out_sel;

    assign acc_row = open_row_reg[acc_bank][ROW_BITS-1:0];
    assign acc_idx = {acc_bank, acc_row, acc_col};
    assign rd_word = mem[acc_idx];

    // Pipeline shift; each stage is one cycle of read latency.
    always_comb begin
        pipe_valid_next = pipe_valid_reg;
        pipe_mask_next  = pipe_mask_reg;
        if (clk_gate) begin
            pipe_valid_next[0] = acc_en && !acc_write;
            pipe_mask_next[0]  = {high_byte_mask, low_byte_mask};
            for (int i = 1; i < PIPE_N; i++) begin
                pipe_valid_next[i] = pipe_valid_reg[i-1];
                pipe_mask_next[i]  = pipe_mask_reg[i-1];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pipe_valid_reg <= '{default: 1'b0};
            pipe_mask_reg  <= '{default: 2'h0};
        end else begin
            pipe_valid_reg <= pipe_valid_next;
            pipe_mask_reg  <= pipe_mask_next;
        end
    end

    // Array writes and read-data stages; the array itself carries no reset.
    always_ff @(posedge ref_clk) begin
        if (clk_gate) begin
            if (acc_en && acc_write && !low_byte_mask) begin
                mem[acc_idx][7:0] <= data_lines_in[7:0];
            end
            if (acc_en && acc_write && !high_byte_mask) begin
                mem[acc_idx][15:8] <= data_lines_in[15:8];
            end
            pipe_data_reg[0] <= rd_word;
            for (int i = 1; i < PIPE_N; i++) begin
                pipe_data_reg[i] <= pipe_data_reg[i-1];
            end
        end
    end

    // Stage 1 is visible at the second edge after the command, stage 2 at the third.
    assign out_sel        = (mode_cl == CL_3) ? 2'h2 : 2'h1;
    assign data_lines_out = pipe_data_reg[out_sel];
    assign data_lines_oe  = {2{pipe_valid_reg[out_sel]}} & ~pipe_mask_reg[out_sel];

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    logic rd_take;
    assign rd_take = clk_gate && acc_en && !acc_write;

    mode_load_a: assert property (cmd == CMD_MODE && clk_gate && !burst_active_reg
        |=> mode_reg == $past(row_col_address)) else $error("mode word not loaded");
    act_open_a: assert property (cmd == CMD_ACT && clk_gate
        |=> row_open_reg[$past(bank_select)] && open_row_reg[$past(bank_select)]
            == $past(row_col_address)) else $error("activate did not open row");
    desel_hold_a: assert property (dev_select_n && !burst_active_reg
        |=> $stable(mode_reg) && $stable(row_open_reg)) else $error("deselect changed state");
    gate_hold_a: assert property (!clk_gate
        |=> $stable(burst_cnt_reg) && $stable(row_open_reg) && $stable(mode_reg))
        else $error("state moved with clock gated");
    pre_all_a: assert property (cmd == CMD_PRE && clk_gate && row_col_address[AUTO_PRE_BIT]
        |=> row_open_reg == '0 && !burst_active_reg) else $error("precharge all failed");
    pre_one_a: assert property (cmd == CMD_PRE && clk_gate && !row_col_address[AUTO_PRE_BIT]
        |=> !row_open_reg[$past(bank_select)]) else $error("bank precharge failed");
    stop_burst_a: assert property (cmd == CMD_STOP && clk_gate
        |=> !burst_active_reg) else $error("burst stop ignored");
    single_write_a: assert property (cmd == CMD_WRITE && clk_gate && single_write
        |=> !burst_active_reg) else $error("write burst in single-write mode");
    burst_step_a: assert property (burst_active_reg && clk_gate && cmd == CMD_NOP
        |=> burst_cnt_reg == 8'($past(burst_cnt_reg) + 8'h01)) else $error("burst stalled");
    auto_pre_a: assert property (burst_active_reg && burst_ap_reg && burst_last
        && clk_gate && cmd == CMD_NOP |=> !row_open_reg[$past(burst_bank_reg)])
        else $error("auto precharge missing");
    lat_two_a: assert property (rd_take && mode_cl != CL_3 ##1 clk_gate
        |=> pipe_valid_reg[out_sel]) else $error("read latency 2 missed");
    lat_three_a: assert property (rd_take && mode_cl == CL_3 ##1 clk_gate[*2]
        |=> pipe_valid_reg[out_sel]) else $error("read latency 3 missed");

    read_burst_c: cover property (rd_take && burst_active_next ##1 rd_take ##1 rd_take);
    write_c:      cover property (clk_gate && acc_en && acc_write);
    stop_c:       cover property (burst_active_reg && cmd == CMD_STOP && clk_gate);

endmodule

// ---- verif/sdc_ctrl_model.sv ----
// Behavioural memory controller driving the SDRAM command, address, mask and write-data pins.
`timescale 1ns/1ps
module sdc_ctrl_model
    import sdc_pkg::*;
(
    input  wire logic              ref_clk,
    output logic                   clk_gate,
    output logic                   dev_select_n,
    output logic                   row_strobe_n,
    output logic                   col_strobe_n,
    output logic                   write_strobe_n,
    output logic      [BANK_W-1:0] bank_select,
    output logic      [ADDR_W-1:0] row_col_address,
    output logic                   low_byte_mask,
    output logic                   high_byte_mask,
    output logic      [DATA_W-1:0] data_lines_in
);
    // ****************************************************************
    // Pin driving
    // ****************************************************************
    // Pins start deselected so nothing is taken while reset is applied.
    initial begin
        {clk_gate, dev_select_n, row_strobe_n, col_strobe_n, write_strobe_n} = 5'h1F;
        {bank_select, row_col_address, low_byte_mask, high_byte_mask} = 16'h0000;
        data_lines_in = 16'h0000;
    end

    // Drives one command just after an edge; it is taken on the following rising edge.
    task automatic cmd(input logic [2:0] rcw, input logic [1:0] b, input logic [11:0] a,
                       input logic [15:0] d, input logic [1:0] m, input logic [1:0] gs);
        @(posedge ref_clk);
        #1;
        {clk_gate, dev_select_n} = gs;
        {row_strobe_n, col_strobe_n, write_strobe_n} = rcw;
        bank_select = b;
        row_col_address = a;
        {high_byte_mask, low_byte_mask} = m;
        data_lines_in = d;
    endtask

    // Idle cycles drive inverted data, so a stale word can never pass for a fresh one.
    task automatic nop(input int n);
        repeat (n) cmd(3'h7, 2'h0, 12'h000, ~data_lines_in, 2'h0, 2'h2);
    endtask

    // Opens a row; accesses that are meant to succeed only go to banks opened here.
    task automatic act(input logic [1:0] b, input logic [11:0] row);
        cmd(3'h3, b, row, ~data_lines_in, 2'h0, 2'h2);
    endtask

    // The run is far shorter than one refresh interval, so a single refresh meets the rate.
    task automatic refresh();
        cmd(3'h1, 2'h0, 12'h000, ~data_lines_in, 2'h0, 2'h2);
    endtask
endmodule

// ---- verif/sdram_command_address_interface_test.sv ----
// Self-checking testbench for the SDRAM device: decode, bursts, masks, cuts and gating.
`timescale 1ns/1ps
`define CHK(got_v, exp_v) begin checks_done++; if ((got_v) !== (exp_v)) begin n_errors++; \
    $display("CHECK FAILED t=%0t got %0h exp %0h", $time, (got_v), (exp_v)); end end
module sdram_command_address_interface_test;
    import sdc_pkg::*;
    logic              ref_clk = 1'b0;
    logic              rst_n = 1'b0;
    logic              clk_gate, dev_select_n, row_strobe_n, col_strobe_n, write_strobe_n;
    logic              low_byte_mask, high_byte_mask;
    logic [BANK_W-1:0] bank_select;
    logic [ADDR_W-1:0] row_col_address;
    logic [DATA_W-1:0] data_lines_in, data_lines_out;
    logic [1:0]        data_lines_oe;
    int                n_errors = 0;
    int                checks_done = 0;
    int                cycles = 0;
    localparam int     CYCLE_LIMIT = 4000;

    // A small array keeps the run short; row width does not affect any check here.
    sdc_sdram_device #(.ROW_BITS(4)) uut (
        .ref_clk(ref_clk), .rst_n(rst_n), .clk_gate(clk_gate), .dev_select_n(dev_select_n),
        .row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n),
        .write_strobe_n(write_strobe_n), .bank_select(bank_select),
        .row_col_address(row_col_address), .low_byte_mask(low_byte_mask),
        .high_byte_mask(high_byte_mask), .data_lines_in(data_lines_in),
        .data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe));
    sdc_ctrl_model ctl (
        .ref_clk(ref_clk), .clk_gate(clk_gate), .dev_select_n(dev_select_n),
        .row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n),
        .write_strobe_n(write_strobe_n), .bank_select(bank_select),
        .row_col_address(row_col_address), .low_byte_mask(low_byte_mask),
        .high_byte_mask(high_byte_mask), .data_lines_in(data_lines_in));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Clock and a cycle ceiling so a hung design still reaches the verdict.
    always #4 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == CYCLE_LIMIT) begin
            n_errors++;
            $display("CHECK FAILED t=%0t run exceeded the cycle limit", $time);
            give_verdict();
        end
    end

    // Reads n words of a burst; masked bytes are undefined, so only enabled bytes compare.
    task automatic rd(input logic [1:0] b, input logic [11:0] a, input int cl, input int n,
                      input logic [15:0] e [4], input logic [1:0] m);
        logic [15:0] keep;
        keep = {{8{~m[1]}}, {8{~m[0]}}};
        ctl.cmd(3'h5, b, a, 16'h0000, m, 2'h2);
        ctl.nop(cl);
        for (int k = 0; k < n; k++) begin
            `CHK(data_lines_oe, ~m);
            `CHK(data_lines_out & keep, e[k] & keep);
            ctl.nop(1);
        end
    endtask

    // Issues a read, optionally a second command cut cycles later, and counts driven words.
    task automatic rd_count(input logic [1:0] b, input logic [11:0] a, input logic [1:0] gs,
                            input int cut, input logic [2:0] rcw, input logic [1:0] cb,
                            input logic [11:0] ca, input int win, output int n);
        n = 0;
        ctl.cmd(3'h5, b, a, 16'h0000, 2'h0, gs);
        for (int i = 1; i <= win; i++) begin
            if (i == cut) begin
                ctl.cmd(rcw, cb, ca, 16'h0000, 2'h0, 2'h2);
            end else begin
                ctl.nop(1);
            end
            if (data_lines_oe !== 2'h0) n++;
        end
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    // Single-word accesses, back-to-back columns and both byte masks.
    task automatic t_basic();
        logic [15:0] e [4];
        ctl.refresh();
        ctl.act(2'h1, 12'h005);
        ctl.cmd(3'h4, 2'h1, 12'h010, 16'h1234, 2'h0, 2'h2);
        ctl.cmd(3'h4, 2'h1, 12'h011, 16'h5678, 2'h0, 2'h2);
        ctl.cmd(3'h4, 2'h1, 12'h010, 16'hFFFF, 2'h1, 2'h2);
        e = '{16'hFF34, 16'h0000, 16'h0000, 16'h0000};
        rd(2'h1, 12'h010, 2, 1, e, 2'h0);
        e[0] = 16'h5678;
        rd(2'h1, 12'h011, 2, 1, e, 2'h2);
        $display("test basic done");
    endtask

    // A wrapped sequential write burst read back in sequential and interleaved order.
    task automatic t_order();
        logic [15:0] e [4];
        ctl.cmd(3'h0, 2'h0, 12'h032, 16'h0000, 2'h0, 2'h2);
        ctl.cmd(3'h4, 2'h1, 12'h022, 16'h0B00, 2'h0, 2'h2);
        for (int k = 1; k < 4; k++) ctl.cmd(3'h7, 2'h1, 12'h000, 16'h0B00 + 16'(k), 2'h0, 2'h2);
        e = '{16'h0B02, 16'h0B03, 16'h0B00, 16'h0B01};
        rd(2'h1, 12'h020, 3, 4, e, 2'h0);
        ctl.cmd(3'h0, 2'h0, 12'h02A, 16'h0000, 2'h0, 2'h2);
        e = '{16'h0B03, 16'h0B02, 16'h0B01, 16'h0B00};
        rd(2'h1, 12'h021, 2, 4, e, 2'h0);
        $display("test order done");
    endtask

    // Each defined burst length code (0, 1, 2, 3, 7) gives its own number of read words.
    task automatic t_lengths();
        logic [2:0] codes [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
        int         lens [5] = '{1, 2, 4, 8, 256};
        int         n;
        for (int i = 0; i < 5; i++) begin
            ctl.cmd(3'h0, 2'h0, 12'h020 | {9'h000, codes[i]}, 16'h0000, 2'h0, 2'h2);
            rd_count(2'h1, 12'h000, 2'h2, 0, 3'h7, 2'h0, 12'h000, 264, n);
            `CHK(n, lens[i]);
        end
        $display("test lengths done");
    endtask

    // In single-write mode the word after a write command is not stored.
    task automatic t_single();
        logic [15:0] e [4];
        ctl.cmd(3'h0, 2'h0, 12'h020, 16'h0000, 2'h0, 2'h2);
        ctl.cmd(3'h4, 2'h1, 12'h031, 16'h5555, 2'h0, 2'h2);
        ctl.cmd(3'h0, 2'h0, 12'h222, 16'h0000, 2'h0, 2'h2);
        ctl.cmd(3'h4, 2'h1, 12'h030, 16'h3030, 2'h0, 2'h2);
        ctl.nop(1);
        e = '{16'h3030, 16'h5555, 16'h0000, 16'h0000};
        rd(2'h1, 12'h030, 2, 2, e, 2'h0);
        $display("test single done");
    endtask

    // Burst stop and precharge cut a burst; precharging another bank does not.
    task automatic t_cut();
        int n;
        ctl.cmd(3'h0, 2'h0, 12'h023, 16'h0000, 2'h0, 2'h2);
        ctl.act(2'h2, 12'h003);
        rd_count(2'h1, 12'h000, 2'h2, 2, 3'h6, 2'h0, 12'h000, 16, n);
        `CHK(n, 2);
        rd_count(2'h1, 12'h000, 2'h2, 2, 3'h2, 2'h2, 12'h000, 16, n);
        `CHK(n, 8);
        rd_count(2'h1, 12'h000, 2'h2, 3, 3'h2, 2'h1, 12'h000, 16, n);
        `CHK(n, 3);
        rd_count(2'h1, 12'h000, 2'h2, 0, 3'h7, 2'h0, 12'h000, 16, n);
        `CHK(n, 0);
        $display("test cut done");
    endtask

    // Auto precharge closes only the accessed bank; precharge with bit ten closes all.
    task automatic t_auto();
        int n;
        ctl.cmd(3'h0, 2'h0, 12'h021, 16'h0000, 2'h0, 2'h2);
        ctl.act(2'h3, 12'h001);
        ctl.act(2'h0, 12'h002);
        ctl.act(2'h2, 12'h003);
        rd_count(2'h3, 12'h400, 2'h2, 0, 3'h7, 2'h0, 12'h000, 8, n);
        `CHK(n, 2);
        rd_count(2'h3, 12'h000, 2'h2, 0, 3'h7, 2'h0, 12'h000, 8, n);
        `CHK(n, 0);
        rd_count(2'h0, 12'h000, 2'h2, 0, 3'h7, 2'h0, 12'h000, 8, n);
        `CHK(n, 2);
        ctl.cmd(3'h2, 2'h0, 12'h400, 16'h0000, 2'h0, 2'h2);
        rd_count(2'h2, 12'h000, 2'h2, 0, 3'h7, 2'h0, 12'h000, 8, n);
        `CHK(n, 0);
        $display("test auto done");
    endtask

    // Deselected or ungated edges are ignored, and a gated-off clock holds the read pipe.
    task automatic t_gate();
        int n;
        ctl.cmd(3'h0, 2'h0, 12'h020, 16'h0000, 2'h0, 2'h2);
        ctl.cmd(3'h3, 2'h1, 12'h005, 16'h0000, 2'h0, 2'h3);
        rd_count(2'h1, 12'h010, 2'h2, 0, 3'h7, 2'h0, 12'h000, 6, n);
        `CHK(n, 0);
        ctl.cmd(3'h3, 2'h1, 12'h005, 16'h0000, 2'h0, 2'h0);
        rd_count(2'h1, 12'h010, 2'h2, 0, 3'h7, 2'h0, 12'h000, 6, n);
        `CHK(n, 0);
        ctl.act(2'h1, 12'h005);
        rd_count(2'h1, 12'h010, 2'h0, 0, 3'h7, 2'h0, 12'h000, 6, n);
        `CHK(n, 0);
        ctl.cmd(3'h5, 2'h1, 12'h010, 16'h0000, 2'h0, 2'h2);
        ctl.nop(1);
        // The gate drops as the word appears, so the following edges must hold it.
        repeat (3) begin
            ctl.cmd(3'h7, 2'h0, 12'h000, 16'h0000, 2'h0, 2'h0);
            `CHK(data_lines_oe, 2'h3);
        end
        `CHK(data_lines_out, 16'hFF34);
        ctl.nop(2);
        `CHK(data_lines_oe, 2'h0);
        $display("test gate done");
    endtask

    // A reset in mid-burst empties the pipe, closes banks and restores the mode word.
    task automatic t_reset();
        logic [15:0] e [4];
        int          n;
        ctl.cmd(3'h0, 2'h0, 12'h033, 16'h0000, 2'h0, 2'h2);
        ctl.cmd(3'h5, 2'h1, 12'h010, 16'h0000, 2'h0, 2'h2);
        ctl.nop(3);
        `CHK(data_lines_oe, 2'h3);
        rst_n = 1'b0;
        ctl.nop(2);
        rst_n = 1'b1;
        `CHK(data_lines_oe, 2'h0);
        rd_count(2'h1, 12'h010, 2'h2, 0, 3'h7, 2'h0, 12'h000, 8, n);
        `CHK(n, 0);
        ctl.act(2'h1, 12'h005);
        e = '{16'hFF34, 16'h0000, 16'h0000, 16'h0000};
        rd(2'h1, 12'h010, 2, 1, e, 2'h0);
        $display("test reset done");
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Reset for sixteen cycles, then the scenarios in an order that keeps banks open.
    initial begin
        repeat (16) @(posedge ref_clk);
        #1;
        rst_n = 1'b1;
        t_basic();
        t_order();
        t_lengths();
        t_single();
        t_cut();
        t_auto();
        t_gate();
        t_reset();
        give_verdict();
    end
endmodule
